// [bsfs_pkg.sv]
// Package: constants and types for the start-up and fault sequencer
package bsfs_pkg;

  // ----------------------------------------
  // Timing counts, in sequencer clock cycles
  // ----------------------------------------
  localparam int unsigned BSFS_PRESTART_CYCLES = 32;
  localparam int unsigned BSFS_DISCHARGE_CYCLES = 256;
  localparam int unsigned BSFS_COOLDOWN_CYCLES = 512;
  localparam int unsigned BSFS_CNT_W = 10;

  // ----------------------------------------
  // Fault counter limits
  // ----------------------------------------
  localparam int unsigned BSFS_FAULT_LIMIT = 4;
  localparam int unsigned BSFS_FCNT_W = 3;

  // ----------------------------------------
  // Comparator inputs, grouped
  // ----------------------------------------
  typedef struct packed {
    logic supply_ok;
    logic ramp_done;
    logic over_window;
    logic under_window;
    logic undervoltage_event;
    logic undervoltage_recovered;
    logic overcurrent_event;
  } bsfs_cmp_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [6:0] {
    BSFS_SHUTDOWN = 7'h01,
    BSFS_DISCHARGE = 7'h02,
    BSFS_PRESTART = 7'h04,
    BSFS_SOFTSTART = 7'h08,
    BSFS_RUN = 7'h10,
    BSFS_COOLDOWN = 7'h20,
    BSFS_COOLRAMP = 7'h40
  } bsfs_state_t;

endpackage

// [bsfs_sync.sv]
// Two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module bsfs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // ----------------------------------------
  // Two flops; first stage read only by second
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule

// [bsfs_fault_counter.sv]
// Consecutive-event fault counter with overflow flag
`timescale 1ns/1ps
module bsfs_fault_counter #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] LIMIT = 3'h4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic sample,
  input wire logic hit,
  // Status
  output logic [WIDTH-1:0] count,
  output logic overflow
);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Clear wins: it marks shutdown or recovery, never a live event
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count <= '0;
    end else if (sample) begin
      if (!hit) begin
        count <= '0;
      end else if (count != LIMIT) begin
        count <= count + 1'b1;
      end
    end
  end

  assign overflow = (count == LIMIT);

endmodule

// [bsfs_sequencer.sv]
// Start-up, power-good and hiccup fault sequencer for a buck regulator
`timescale 1ns/1ps

// Summary of operation
// R01: With enable high, stay in shutdown until supply-sense is above threshold.
// R02: Turn on supply-sense sink only while supply-sense is below threshold.
// R03: After supply and enable are both good, wait 32 cycles before soft-start.
// R04: Soft-start ends when the ramp comparator reports equality with reference.
// R05: On supply loss or enable low, discharge ramp capacitor for 256 cycles.
// R06: Release power-good only after soft-start completes, as the final step.
// R07: Power-good goes low at once when enable goes low.
// R08: Above 111% pull power-good low until feedback falls to 107.5%.
// R09: Below 89% pull power-good low until feedback rises to 92.5%.
// R10: Each undervoltage comparator trip increments the undervoltage counter.
// R11: Clear undervoltage counter when feedback recovers past threshold plus hysteresis.
// R12: Four consecutive undervoltage events shut down and pull power-good low.
// R13: After a fault shutdown, wait 512 cycles plus one soft-start before retry.
// R14: Clear undervoltage counter on entering the cool-down delay.
// R15: After cool-down run normal soft-start; success raises power-good. Code leaves the ramp charged, so retry soft-start lasts one cycle.
// R16: Retry shuts down only on another undervoltage overflow; repeats indefinitely.
// R17: Sample high-side current once per switching cycle from the sense blocks.
// R18: On overcurrent turn upper switch off until the next switching cycle.
// R19: Overcurrent counter: first hit sets one, hits increment, a clean cycle clears.
// R20: Four sequential overcurrent hits overflow, shut down, pull power-good low.
// R21: Clear overcurrent counter on entering the cool-down delay.
// R22: During retry, shut down for overcurrent only on another overflow.
// R23: Enable low puts the device into shutdown.
// R24: In shutdown all power switches off, phase outputs high impedance.
// R25: Synchronise all comparator outputs before the sequencer and counters use them.
module bsfs_sequencer
  import bsfs_pkg::*;
#(
  parameter int unsigned PRESTART_CYCLES = BSFS_PRESTART_CYCLES,
  parameter int unsigned DISCHARGE_CYCLES = BSFS_DISCHARGE_CYCLES,
  parameter int unsigned COOLDOWN_CYCLES = BSFS_COOLDOWN_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Enable and comparators, asynchronous
  input wire logic enable_in,
  input wire bsfs_cmp_t cmp_in,
  // Switching-cycle marker from the oscillator, same clock domain
  input wire logic cycle_start,
  // Modulator request for the upper switch, same clock domain
  input wire logic pwm_request,
  // Analog controls
  output logic supply_sink_on,
  output logic ramp_discharge,
  output logic ramp_charge,
  // Power stage
  output logic stage_enable,
  output logic upper_switch_on,
  // Open-drain power-good
  output logic power_good_out_o,
  output logic power_good_out_oe,
  // Status
  output logic fault_undervoltage,
  output logic fault_overcurrent
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  localparam int unsigned SYNC_W = $bits(bsfs_cmp_t) + 1;
  localparam logic [BSFS_FCNT_W-1:0] LIMIT = BSFS_FCNT_W'(BSFS_FAULT_LIMIT);
  localparam logic [BSFS_CNT_W-1:0] PRE_LAST = BSFS_CNT_W'(PRESTART_CYCLES - 1);
  localparam logic [BSFS_CNT_W-1:0] DIS_LAST = BSFS_CNT_W'(DISCHARGE_CYCLES - 1);
  localparam logic [BSFS_CNT_W-1:0] COOL_LAST = BSFS_CNT_W'(COOLDOWN_CYCLES - 1);

  logic [SYNC_W-1:0] sync_bus;
  bsfs_cmp_t cmp;
  logic enable_s;

  bsfs_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({enable_in, cmp_in}),
    .sync_out(sync_bus)
  ); // [R25]

  assign enable_s = sync_bus[SYNC_W-1];
  assign cmp = bsfs_cmp_t'(sync_bus[SYNC_W-2:0]);

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  bsfs_state_t state_reg;
  bsfs_state_t state_next;
  logic [BSFS_CNT_W-1:0] timer_reg;
  logic timer_clear;
  logic start_ok;
  logic uv_overflow;
  logic oc_overflow;
  logic fault_trip;
  logic enter_cool;
  logic uv_prev_reg;
  logic uv_rise;
  logic oc_latched_reg;
  logic oc_sampled_reg;
  logic oc_sample_now;
  logic [BSFS_FCNT_W-1:0] uv_count;
  logic [BSFS_FCNT_W-1:0] oc_count;
  logic window_low_reg;
  logic window_high_reg;
  logic active;

  assign start_ok = enable_s && cmp.supply_ok; // [R01]
  assign active = (state_reg == BSFS_SOFTSTART) || (state_reg == BSFS_RUN)
    || (state_reg == BSFS_COOLRAMP);
  assign fault_trip = uv_overflow || oc_overflow;
  assign enter_cool = active && (state_reg != BSFS_COOLRAMP) && fault_trip;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    timer_clear = 1'b0;
    case (state_reg)
      BSFS_SHUTDOWN: begin
        if (start_ok) begin
          state_next = BSFS_PRESTART; // [R01]
          timer_clear = 1'b1;
        end
      end
      BSFS_DISCHARGE: begin
        if (timer_reg == DIS_LAST) begin
          state_next = BSFS_SHUTDOWN; // [R05]
        end
      end
      BSFS_PRESTART: begin
        if (timer_reg == PRE_LAST) begin
          state_next = BSFS_SOFTSTART; // [R03]
        end
      end
      BSFS_SOFTSTART: begin
        if (fault_trip) begin
          state_next = BSFS_COOLDOWN; // [R12] [R20] [R16] [R22]
          timer_clear = 1'b1;
        end else if (cmp.ramp_done) begin
          state_next = BSFS_RUN; // [R04] [R15]
        end
      end
      BSFS_RUN: begin
        if (fault_trip) begin
          state_next = BSFS_COOLDOWN; // [R12] [R20]
          timer_clear = 1'b1;
        end
      end
      BSFS_COOLDOWN: begin
        if (timer_reg == COOL_LAST) begin
          state_next = BSFS_COOLRAMP; // [R13]
        end
      end
      BSFS_COOLRAMP: begin
        // Extra soft-start length while still idle; hardware keeps cooling
        if (cmp.ramp_done) begin
          state_next = BSFS_SOFTSTART; // [R13] [R15]
        end
      end
      default: begin
        state_next = BSFS_SHUTDOWN;
      end
    endcase
    // Supply loss or enable low overrides everything
    if (!start_ok && (state_reg != BSFS_SHUTDOWN) && (state_reg != BSFS_DISCHARGE)) begin
      state_next = BSFS_DISCHARGE; // [R05] [R23]
      timer_clear = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= BSFS_DISCHARGE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || timer_clear || (state_reg != state_next)) begin
      timer_reg <= '0;
    end else if (timer_reg != {BSFS_CNT_W{1'b1}}) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // Ramp capacitor control
  // ----------------------------------------
  // Cool-down ramp reuses the capacitor to time one soft-start interval
  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_discharge <= 1'b1;
      ramp_charge <= 1'b0;
    end else begin
      ramp_discharge <= (state_next == BSFS_DISCHARGE) || (state_next == BSFS_SHUTDOWN)
        || (state_next == BSFS_PRESTART) || (state_next == BSFS_COOLDOWN); // [R05]
      ramp_charge <= (state_next == BSFS_SOFTSTART) || (state_next == BSFS_RUN)
        || (state_next == BSFS_COOLRAMP);
    end
  end

  assign supply_sink_on = !cmp.supply_ok; // [R02]

  // ----------------------------------------
  // Undervoltage counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      uv_prev_reg <= 1'b0;
    end else begin
      uv_prev_reg <= cmp.undervoltage_event;
    end
  end

  assign uv_rise = cmp.undervoltage_event && !uv_prev_reg;

  // Count only in soft-start, run and cool-down ramp; ties each trip to one count
  bsfs_fault_counter #(
    .WIDTH(BSFS_FCNT_W),
    .LIMIT(LIMIT)
  ) u_uv_count (
    .clk(clk),
    .rst(rst),
    .clear(enter_cool || !active || cmp.undervoltage_recovered), // [R11] [R14]
    .sample(uv_rise && active), // [R10]
    .hit(1'b1),
    .count(uv_count),
    .overflow(uv_overflow)
  );

  // ----------------------------------------
  // Overcurrent sampling and counter
  // ----------------------------------------
  assign oc_sample_now = cycle_start && active; // [R17]

  // A hit on the cycle-start edge belongs to the new cycle, so set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_latched_reg <= 1'b0;
    end else if (cmp.overcurrent_event) begin
      oc_latched_reg <= 1'b1; // [R18]
    end else if (cycle_start) begin
      oc_latched_reg <= 1'b0; // [R18]
    end
  end

  // Remembers a hit seen in the cycle just closing
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_sampled_reg <= 1'b0;
    end else if (cmp.overcurrent_event) begin
      oc_sampled_reg <= 1'b1;
    end else if (cycle_start) begin
      oc_sampled_reg <= 1'b0;
    end
  end

  bsfs_fault_counter #(
    .WIDTH(BSFS_FCNT_W),
    .LIMIT(LIMIT)
  ) u_oc_count (
    .clk(clk),
    .rst(rst),
    .clear(enter_cool || !active), // [R21]
    .sample(oc_sample_now),
    .hit(oc_sampled_reg), // [R19]
    .count(oc_count),
    .overflow(oc_overflow)
  );

  // ----------------------------------------
  // Power stage
  // ----------------------------------------
  assign stage_enable = active && (state_reg != BSFS_COOLRAMP); // [R24]
  // Cut is combinational so the switch drops in the hit's own cycle
  assign upper_switch_on = stage_enable && pwm_request
    && !oc_latched_reg && !cmp.overcurrent_event; // [R18]

  // ----------------------------------------
  // Power-good window
  // ----------------------------------------
  // Comparators carry their own hysteresis: trip vs release thresholds
  always_ff @(posedge clk) begin
    if (rst) begin
      window_high_reg <= 1'b0;
    end else if (cmp.over_window) begin
      window_high_reg <= 1'b1; // [R08]
    end else begin
      window_high_reg <= 1'b0; // [R08]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      window_low_reg <= 1'b0;
    end else if (cmp.under_window) begin
      window_low_reg <= 1'b1; // [R09]
    end else begin
      window_low_reg <= 1'b0; // [R09]
    end
  end

  // Enable from the synchronised pin (enable_s) so the drop is not delayed by sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      power_good_out_oe <= 1'b1;
    end else begin
      power_good_out_oe <= !(enable_s && (state_next == BSFS_RUN)
        && !window_high_reg && !window_low_reg); // [R06] [R07] [R12] [R20]
    end
  end

  assign power_good_out_o = 1'b0;

  // ----------------------------------------
  // Fault status
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_undervoltage <= 1'b0;
      fault_overcurrent <= 1'b0;
    end else if (enter_cool) begin
      fault_undervoltage <= uv_overflow;
      fault_overcurrent <= oc_overflow;
    end else if (state_reg == BSFS_RUN) begin
      fault_undervoltage <= 1'b0;
      fault_overcurrent <= 1'b0;
    end
  end

endmodule

// [bsfs_checker.sv]
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module bsfs_checker
  import bsfs_pkg::*;
#(
  parameter int unsigned PRESTART_CYCLES = BSFS_PRESTART_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire logic enable_in,
  input wire bsfs_cmp_t cmp_in,
  // Outputs
  input wire logic supply_sink_on,
  input wire logic ramp_discharge,
  input wire logic stage_enable,
  input wire logic upper_switch_on,
  input wire logic power_good_out_oe,
  input wire logic fault_undervoltage,
  input wire logic fault_overcurrent
);
  // ----------------------------------------
  // Checks, two sync flops plus one state edge
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_sink_on;
    !cmp_in.supply_ok [*3] |-> supply_sink_on;
  endproperty
  a_sink_on: assert property (p_sink_on) else $error("sink off at low supply");
  property p_sink_off;
    cmp_in.supply_ok [*3] |-> !supply_sink_on;
  endproperty
  a_sink_off: assert property (p_sink_off) else $error("sink on at good supply");
  property p_no_supply;
    !cmp_in.supply_ok [*4] |-> !stage_enable;
  endproperty
  a_no_supply: assert property (p_no_supply) else $error("stage on at low supply");
  property p_en_low;
    !enable_in [*4] |-> power_good_out_oe && ramp_discharge;
  endproperty
  a_en_low: assert property (p_en_low) else $error("enable low ignored");
  property p_release;
    $fell(power_good_out_oe) |-> stage_enable && $past(cmp_in.ramp_done, 2);
  endproperty
  a_release: assert property (p_release) else $error("early release");
  property p_sw_off;
    !stage_enable |-> !upper_switch_on;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("switch on in shutdown");
  property p_oc_cut;
    $past(cmp_in.overcurrent_event, 2) |-> !upper_switch_on;
  endproperty
  a_oc_cut: assert property (p_oc_cut) else $error("switch on at overcurrent");
  property p_prestart;
    $rose(stage_enable) |-> $past(enable_in && cmp_in.supply_ok, PRESTART_CYCLES + 3);
  endproperty
  a_prestart: assert property (p_prestart) else $error("pre-start too short");
  property p_fault;
    $rose(fault_overcurrent || fault_undervoltage)
      |-> ##1 (!stage_enable && power_good_out_oe) [*8];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shut down");
endmodule

bind bsfs_sequencer bsfs_checker #(.PRESTART_CYCLES(PRESTART_CYCLES)) u_chk (.clk, .rst,
  .enable_in, .cmp_in, .supply_sink_on, .ramp_discharge, .stage_enable, .upper_switch_on,
  .power_good_out_oe, .fault_undervoltage, .fault_overcurrent);

// [bsfs_front_model.sv]
// Far-side model: oscillator, ramp capacitor and power-good pull-up
`timescale 1ns/1ps
module bsfs_front_model #(
  parameter int RAMP = 6,
  parameter int PER = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the sequencer
  input wire logic ramp_charge,
  input wire logic ramp_discharge,
  input wire logic pg_o,
  input wire logic pg_oe,
  // To the sequencer and bench
  output logic ramp_done,
  output logic cycle_start,
  output logic pg_wire
);
  // ----------------------------------------
  // Behaviour
  // ----------------------------------------
  logic [3:0] lvl_reg;
  logic [3:0] ph_reg;
  always_ff @(posedge clk) begin
    if (ramp_discharge) begin
      lvl_reg <= 4'h0;
    end else if (ramp_charge && lvl_reg < 4'(RAMP)) begin
      lvl_reg <= lvl_reg + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    ph_reg <= (rst || ph_reg == 4'(PER - 1)) ? 4'h0 : ph_reg + 4'h1;
  end
  // Done drops when the cap is drained, as a real comparator would
  assign ramp_done = lvl_reg == 4'(RAMP);
  assign cycle_start = ph_reg == 4'h0;
  assign pg_wire = pg_oe ? pg_o : 1'b1;
endmodule

// [tb_top.sv]
// Self-checking bench for the start-up and fault sequencer
`timescale 1ns/1ps
module tb_top
  import bsfs_pkg::*;
;
  // ----------------------------------------
  // Set-up, short counts keep the run brief
  // ----------------------------------------
  localparam int P = 4;
  localparam int D = 8;
  localparam int C = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic pwm = 1'b0;
  bsfs_cmp_t cmp_drv = '0;
  bsfs_cmp_t cmp_w;
  logic rdone, cyc, sink, dis, chg, stage, up, pg_o, pg_oe, f_uv, f_oc, pg;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  always_comb begin
    cmp_w = cmp_drv;
    cmp_w.ramp_done = rdone;
  end
  bsfs_sequencer #(.PRESTART_CYCLES(P), .DISCHARGE_CYCLES(D), .COOLDOWN_CYCLES(C)) dut (
    .clk(clk), .rst(rst), .enable_in(en), .cmp_in(cmp_w), .cycle_start(cyc),
    .pwm_request(pwm), .supply_sink_on(sink), .ramp_discharge(dis), .ramp_charge(chg),
    .stage_enable(stage), .upper_switch_on(up), .power_good_out_o(pg_o),
    .power_good_out_oe(pg_oe), .fault_undervoltage(f_uv), .fault_overcurrent(f_oc));
  bsfs_front_model fm (.clk(clk), .rst(rst), .ramp_charge(chg), .ramp_discharge(dis),
    .pg_o(pg_o), .pg_oe(pg_oe), .ramp_done(rdone), .cycle_start(cyc), .pg_wire(pg));
  task step(input int n = 1);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic probe(input int k);
    case (k)
      0: return pg;
      1: return stage;
      2: return f_oc;
      default: return f_uv;
    endcase
  endfunction
  task automatic wait_on(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (probe(k) !== v) begin
      if (n == lim) begin
        n_mismatch++;
        $display("unexpected at %0t ns: wait ran out", $time);
        report_and_stop();
      end
      step();
      n++;
    end
  endtask
  task pulse(input int b);
    cmp_drv[b] = 1'b1;
    step(3);
    cmp_drv[b] = 1'b0;
    step(3);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_start;
    int n;
    en = 1'b1;
    step(D + 4);
    check(sink === 1'b1 && stage === 1'b0, "start without supply");
    cmp_drv.supply_ok = 1'b1;
    wait_on(1, 1'b1, 60, n);
    check(n == P + 3 && sink === 1'b0, "pre-start length");
    wait_on(0, 1'b1, 60, n);
    check(n >= 6 && rdone === 1'b1, "release before ramp end");
  endtask
  task automatic t_window;
    int n;
    for (int i = 0; i < 2; i++) begin
      cmp_drv[4 - i] = 1'b1;
      step(4);
      check(pg === 1'b0 && stage === 1'b1, "window kept good");
      cmp_drv[4 - i] = 1'b0;
      wait_on(0, 1'b1, 5, n);
    end
  endtask
  task automatic t_oc;
    int n;
    pwm = 1'b1;
    step();
    check(up === 1'b1, "switch idle in run");
    cmp_drv.overcurrent_event = 1'b1;
    step(3);
    check(up === 1'b0, "switch kept on");
    step(4);
    cmp_drv.overcurrent_event = 1'b0;
    step(10);
    cmp_drv.overcurrent_event = 1'b1;
    step(7);
    check(f_oc === 1'b0 && pg === 1'b1, "count not cleared");
    wait_on(2, 1'b1, 40, n);
    check(pg === 1'b0 && stage === 1'b0, "no shutdown");
    cmp_drv.overcurrent_event = 1'b0;
    wait_on(1, 1'b1, 300, n);
    check(n >= C, "cool-down short");
    wait_on(0, 1'b1, 60, n);
    step();
    check(f_oc === 1'b0, "flag kept after retry");
  endtask
  task automatic t_uv;
    int n;
    for (int k = 0; k < 7; k++) begin
      pulse((k == 3 || k == 6) ? 1 : 2);
    end
    check(f_uv === 1'b0 && pg === 1'b1, "count not cleared");
    for (int k = 0; k < 4; k++) begin
      pulse(2);
    end
    wait_on(3, 1'b1, 10, n);
    check(pg === 1'b0 && stage === 1'b0, "no shutdown");
    wait_on(1, 1'b1, 300, n);
    for (int k = 0; k < 3; k++) begin
      pulse(2);
    end
    wait_on(0, 1'b1, 60, n);
    check(f_uv === 1'b0, "retry failed");
  endtask
  task automatic t_off;
    en = 1'b0;
    step(4);
    check(pg === 1'b0 && stage === 1'b0 && up === 1'b0, "still on");
    step(D - 2);
    check(dis === 1'b1, "discharge short");
  endtask
  initial begin
    step(2);
    rst = 1'b0;
    t_start();
    t_window();
    t_oc();
    t_uv();
    t_off();
    report_and_stop();
  end
  initial begin
    #2000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
